// >>> common/mas_pkg.sv
// Shared constants, types and helpers for the multiply/add slice.
`default_nettype none
package mas_pkg;
	localparam int MAS_LANE_W   = 18;
	localparam int MAS_NINE_W   = 9;
	localparam int MAS_PROD_W   = 36;
	localparam int MAS_WIDE_W   = 72;
	localparam int MAS_ACC_W    = 52;
	localparam int MAS_UNITS    = 4;
	localparam int MAS_LANES    = 8;
	localparam int MAS_ACCS     = 2;
	localparam int MAS_CTL_W    = 6;
	// Field positions inside the control word.
	localparam int MAS_CTL_SA   = 5;
	localparam int MAS_CTL_SB   = 4;
	localparam int MAS_CTL_UP   = 3;
	localparam int MAS_CTL_LO   = 2;
	localparam int MAS_CTL_LD   = 0;
	localparam logic [1:0] MAS_CTL_NONE  = 2'h0;
	localparam logic [1:0] MAS_CTL_ONCE  = 2'h1;
	localparam logic [1:0] MAS_CTL_TWICE = 2'h2;
	localparam logic [MAS_CTL_W-1:0] MAS_CTL_RST = 6'h00;

	typedef enum logic [3:0] {
		MAS_SIMPLE = 4'b0001,
		MAS_MAC    = 4'b0010,
		MAS_ADD2   = 4'b0100,
		MAS_ADD4   = 4'b1000
	} mas_mode_e;

	typedef enum logic [2:0] {
		MAS_W9  = 3'b001,
		MAS_W18 = 3'b010,
		MAS_W36 = 3'b100
	} mas_size_e;

	typedef logic [MAS_LANE_W-1:0]                 mas_lane_t;
	typedef logic [MAS_UNITS-1:0][MAS_LANE_W-1:0]  mas_quad_t;
	typedef logic [MAS_LANES-1:0][MAS_LANE_W-1:0]  mas_oct_t;

	// Extends the low w bits of v to the wide width, signed when s is set.
	function automatic logic [MAS_WIDE_W-1:0] mas_ext(
		input logic [MAS_WIDE_W-1:0] v,
		input int unsigned           w,
		input logic                  s);
		logic [MAS_WIDE_W-1:0] t;
		t = v << (MAS_WIDE_W - w);
		if (s) begin
			mas_ext = MAS_WIDE_W'($signed(t) >>> (MAS_WIDE_W - w));
		end else begin
			mas_ext = t >> (MAS_WIDE_W - w);
		end
	endfunction
endpackage
`default_nettype wire

// >>> common/mas_mul_if.sv
// Operand and product bundle between the slice and one multiplier unit.
`timescale 1ns/1ps
`default_nettype none
interface mas_mul_if;
	import mas_pkg::*;
	logic [MAS_LANE_W-1:0] a;
	logic [MAS_LANE_W-1:0] b;
	logic                  sign_a;
	logic                  sign_b;
	logic                  split;
	logic [MAS_PROD_W-1:0] prod;
	modport user (output a, b, sign_a, sign_b, split, input prod);
	modport unit (input a, b, sign_a, sign_b, split, output prod);
endinterface
`default_nettype wire

// >>> hw/mas_mul_unit.sv
// One 18x18 multiplier that can also work as two independent 9x9 ones.
`timescale 1ns/1ps
`default_nettype none
module mas_mul_unit (
	// Operands and product
	mas_mul_if.unit mul
);
	import mas_pkg::*;

	logic signed [MAS_LANE_W:0]     ea;
	logic signed [MAS_LANE_W:0]     eb;
	logic signed [2*MAS_LANE_W+1:0] pf;
	logic signed [MAS_NINE_W:0]     la;
	logic signed [MAS_NINE_W:0]     lb;
	logic signed [MAS_NINE_W:0]     ha;
	logic signed [MAS_NINE_W:0]     hb;
	logic signed [2*MAS_NINE_W+1:0] pl;
	logic signed [2*MAS_NINE_W+1:0] ph;

	// One extra bit per operand carries the sign, so full precision holds.
	assign ea = $signed({mul.sign_a & mul.a[MAS_LANE_W-1], mul.a});
	assign eb = $signed({mul.sign_b & mul.b[MAS_LANE_W-1], mul.b});
	assign pf = ea * eb;
	assign la = $signed({mul.sign_a & mul.a[MAS_NINE_W-1],
		mul.a[MAS_NINE_W-1:0]});
	assign lb = $signed({mul.sign_b & mul.b[MAS_NINE_W-1],
		mul.b[MAS_NINE_W-1:0]});
	assign ha = $signed({mul.sign_a & mul.a[MAS_LANE_W-1],
		mul.a[MAS_LANE_W-1:MAS_NINE_W]});
	assign hb = $signed({mul.sign_b & mul.b[MAS_LANE_W-1],
		mul.b[MAS_LANE_W-1:MAS_NINE_W]});
	assign pl = la * lb;
	assign ph = ha * hb;
	assign mul.prod = mul.split ?
		{ph[MAS_LANE_W-1:0], pl[MAS_LANE_W-1:0]} : pf[MAS_PROD_W-1:0];
endmodule
`default_nettype wire

// >>> hw/mas_slice.sv
// Multiply/add datapath slice with four exclusive operating modes.
`timescale 1ns/1ps
`default_nettype none
module mas_slice (
	// Clock and reset
	input  wire logic                MCLK,
	input  wire logic                RST_B,
	// Configuration
	input  wire mas_pkg::mas_mode_e  MODE,
	input  wire mas_pkg::mas_size_e  SIZE,
	input  wire logic                OUT_REG,
	input  wire logic [1:0]          CTRL_STAGES,
	input  wire logic                SHIFT_A_EN,
	input  wire logic                SHIFT_B_EN,
	// Control group
	input  wire logic                SIGN_A,
	input  wire logic                SIGN_B,
	input  wire logic                ADD_SUBTRACT_SELECT_UPPER,
	input  wire logic                ADD_SUBTRACT_SELECT_LOWER,
	input  wire logic [1:0]          ACC_LOAD,
	// Data lanes
	input  wire mas_pkg::mas_quad_t  DATA_A,
	input  wire mas_pkg::mas_quad_t  DATA_B,
	output var   mas_pkg::mas_oct_t  DATA_OUT,
	output logic [1:0]               OVERFLOW,
	// Shift chain
	input  wire mas_pkg::mas_lane_t  SHIFT_IN_A,
	input  wire mas_pkg::mas_lane_t  SHIFT_IN_B,
	output var   mas_pkg::mas_lane_t SHIFT_OUT_A,
	output var   mas_pkg::mas_lane_t SHIFT_OUT_B
);
	import mas_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		mas_quad_t                            op_a;
		mas_quad_t                            op_b;
		logic [MAS_UNITS-1:0][MAS_PROD_W-1:0] prod;
		logic [MAS_CTL_W-1:0]                 ctl_d1;
		logic [MAS_CTL_W-1:0]                 ctl_d2;
		logic [MAS_ACCS-1:0][MAS_ACC_W-1:0]   acc;
		logic [MAS_ACCS-1:0]                  ovf;
		mas_oct_t                             out_q;
	} mas_state_s;

	mas_state_s                            st;
	mas_state_s                            next_st;
	logic [MAS_CTL_W-1:0]                  ctl_now;
	logic [MAS_CTL_W-1:0]                  ctl;
	logic                                  psg;
	logic                                  is_36;
	logic                                  is_mac;
	logic                                  up;
	logic                                  lo;
	logic [MAS_UNITS-1:0][MAS_PROD_W-1:0]  prod_w;
	logic [MAS_UNITS-1:0][MAS_WIDE_W-1:0]  pe;
	logic [MAS_UNITS-1:0][1:0][MAS_WIDE_W-1:0] ph;
	logic [MAS_WIDE_W-1:0]                 wide;
	logic [MAS_WIDE_W-1:0]                 s0;
	logic [MAS_WIDE_W-1:0]                 s1;
	logic [1:0][MAS_WIDE_W-1:0]            q01;
	logic [1:0][MAS_WIDE_W-1:0]            q23;
	logic [MAS_ACCS-1:0][MAS_ACC_W-1:0]    ld_val;
	logic [MAS_ACCS-1:0][MAS_ACC_W:0]      step;
	mas_oct_t                              res;
	mas_oct_t                              acc_out;

	// ------------------------------------------------------------
	// Control staging and multiplier units
	// ------------------------------------------------------------
	assign ctl_now = {SIGN_A, SIGN_B, ADD_SUBTRACT_SELECT_UPPER,
		ADD_SUBTRACT_SELECT_LOWER, ACC_LOAD};
	assign ctl = (CTRL_STAGES == MAS_CTL_NONE) ? ctl_now :
		(CTRL_STAGES == MAS_CTL_ONCE) ? st.ctl_d1 : st.ctl_d2;
	assign psg    = ctl[MAS_CTL_SA] | ctl[MAS_CTL_SB];
	assign up     = ctl[MAS_CTL_UP];
	assign lo     = ctl[MAS_CTL_LO];
	assign is_36  = (SIZE == MAS_W36);
	assign is_mac = (MODE == MAS_MAC);

	mas_mul_if mul[MAS_UNITS] ();

	for (genvar i = 0; i < MAS_UNITS; i++) begin : g_unit
		// In wide size the units see operand halves: low*low, high*low,
		// low*high and high*high, signed only on the high halves.
		localparam int HA = i % 2;
		localparam int HB = i / 2;
		assign mul[i].a      = is_36 ? st.op_a[HA] : st.op_a[i];
		assign mul[i].b      = is_36 ? st.op_b[HB] : st.op_b[i];
		assign mul[i].sign_a = ctl[MAS_CTL_SA] & (!is_36 || HA == 1);
		assign mul[i].sign_b = ctl[MAS_CTL_SB] & (!is_36 || HB == 1);
		assign mul[i].split  = (SIZE == MAS_W9) && !is_mac;
		assign prod_w[i]     = mul[i].prod;
		mas_mul_unit u_mul (
			.mul (mul[i])
		);
	end

	// ------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------
	always_comb begin
		next_st        = st;
		next_st.ctl_d1 = ctl_now;
		next_st.ctl_d2 = st.ctl_d1;
		// Chained operands move one unit along; wide size forbids it.
		for (int i = 0; i < MAS_UNITS; i++) begin
			next_st.op_a[i] = DATA_A[i];
			next_st.op_b[i] = DATA_B[i];
			if (SHIFT_A_EN && !is_36) begin
				next_st.op_a[i] = (i == 0) ? SHIFT_IN_A : st.op_a[i-1];
			end
			if (SHIFT_B_EN && !is_36) begin
				next_st.op_b[i] = (i == 0) ? SHIFT_IN_B : st.op_b[i-1];
			end
			next_st.prod[i] = prod_w[i];
			pe[i] = mas_ext(MAS_WIDE_W'(st.prod[i]), MAS_PROD_W, psg);
			for (int h = 0; h < 2; h++) begin
				ph[i][h] = mas_ext(MAS_WIDE_W'(
					st.prod[i][h*MAS_LANE_W +: MAS_LANE_W]), MAS_LANE_W, psg);
			end
		end

		// Partial products realigned by their operand-half weights.
		wide = pe[0] + ((mas_ext(MAS_WIDE_W'(st.prod[1]), MAS_PROD_W,
			ctl[MAS_CTL_SA])
			+ mas_ext(MAS_WIDE_W'(st.prod[2]), MAS_PROD_W,
			ctl[MAS_CTL_SB])) << MAS_LANE_W) + (pe[3] << MAS_PROD_W);
		wide = wide - (mas_ext(MAS_WIDE_W'(st.prod[0]), MAS_PROD_W, psg)
			- MAS_WIDE_W'(st.prod[0]));

		// First stage: units one and two follow the upper select, units three and
		// four the lower one; a complex product uses one of each.
		s0 = up ? pe[0] + pe[1] : pe[0] - pe[1];
		s1 = lo ? pe[2] + pe[3] : pe[2] - pe[3];
		for (int h = 0; h < 2; h++) begin
			q01[h] = up ? ph[0][h] + ph[1][h] : ph[0][h] - ph[1][h];
			q23[h] = lo ? ph[2][h] + ph[3][h] : ph[2][h] - ph[3][h];
		end

		// Accumulators: unit two feeds the first, unit four the second.
		next_st.ovf = '0;
		for (int k = 0; k < MAS_ACCS; k++) begin
			ld_val[k] = pe[2*k+1][MAS_ACC_W-1:0];
			step[k] = (k == 0 ? up : lo) ?
				{psg & st.acc[k][MAS_ACC_W-1], st.acc[k]}
				+ {ld_val[k][MAS_ACC_W-1] & psg, ld_val[k]} :
				{psg & st.acc[k][MAS_ACC_W-1], st.acc[k]}
				- {ld_val[k][MAS_ACC_W-1] & psg, ld_val[k]};
			if (is_mac) begin
				if (ctl[MAS_CTL_LD + k]) begin
					next_st.acc[k] = ld_val[k];
				end else begin
					next_st.acc[k] = step[k][MAS_ACC_W-1:0];
					next_st.ovf[k] = psg ?
						step[k][MAS_ACC_W] != step[k][MAS_ACC_W-1] :
						step[k][MAS_ACC_W];
				end
			end
			acc_out[4*k +: 4] = mas_ext(MAS_WIDE_W'(st.acc[k]), MAS_ACC_W, psg);
		end

		// Output selector by mode and product size.
		res = '0;
		case (MODE)
			MAS_SIMPLE: begin
				if (is_36) begin
					res[3:0] = wide;
				end else begin
					res = st.prod;
				end
			end
			MAS_ADD2: begin
				if (SIZE == MAS_W9) begin
					res = {q23[1][MAS_PROD_W-1:0], q23[0][MAS_PROD_W-1:0],
						q01[1][MAS_PROD_W-1:0], q01[0][MAS_PROD_W-1:0]};
				end else begin
					res = {s1, s0};
				end
			end
			MAS_ADD4: begin
				if (SIZE == MAS_W9) begin
					res = {q01[1] + q23[1], q01[0] + q23[0]};
				end else begin
					res[3:0] = s0 + s1;
				end
			end
			default: begin
				res = acc_out;
			end
		endcase
		next_st.out_q = res;
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Accumulators always come from flops, so the output register choice
	// only matters for the other modes.
	assign DATA_OUT    = is_mac ? acc_out : (OUT_REG ? st.out_q : res);
	assign OVERFLOW    = st.ovf;
	assign SHIFT_OUT_A = st.op_a[MAS_UNITS-1];
	assign SHIFT_OUT_B = st.op_b[MAS_UNITS-1];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [MAS_WIDE_W+1:0] wide_ref;
	assign wide_ref = $signed({ctl[MAS_CTL_SA] & st.op_a[1][MAS_LANE_W-1],
		st.op_a[1], st.op_a[0]})
		* $signed({ctl[MAS_CTL_SB] & st.op_b[1][MAS_LANE_W-1],
		st.op_b[1], st.op_b[0]});

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	property p_ovf_mac_only;
		!is_mac |=> OVERFLOW == '0;
	endproperty
	a_ovf_mac_only: assert property (p_ovf_mac_only)
		else $error("overflow outside accumulate mode");

	property p_acc_load;
		(is_mac && ctl[MAS_CTL_LD]) |=> st.acc[0] == $past(ld_val[0]);
	endproperty
	a_acc_load: assert property (p_acc_load)
		else $error("load did not take the product");

	property p_acc_add;
		(is_mac && !ctl[MAS_CTL_LD] && up)
			|=> st.acc[0] == $past(st.acc[0]) + $past(ld_val[0]);
	endproperty
	a_acc_add: assert property (p_acc_add)
		else $error("accumulate add wrong");

	property p_acc_sub;
		(is_mac && !ctl[MAS_CTL_LD] && !up)
			|=> st.acc[0] == $past(st.acc[0]) - $past(ld_val[0]);
	endproperty
	a_acc_sub: assert property (p_acc_sub)
		else $error("accumulate subtract wrong");

	property p_ovf_unsigned;
		(is_mac && !psg && !ctl[MAS_CTL_LD] && up)
			|=> OVERFLOW[0] == (st.acc[0] < $past(st.acc[0]));
	endproperty
	a_ovf_unsigned: assert property (p_ovf_unsigned)
		else $error("unsigned wrap not flagged");

	property p_simple_direct;
		(MODE == MAS_SIMPLE && SIZE == MAS_W18 && !OUT_REG)
			|-> DATA_OUT == st.prod;
	endproperty
	a_simple_direct: assert property (p_simple_direct)
		else $error("simple product not routed");

	property p_out_reg;
		(!is_mac && OUT_REG) ##1 (!is_mac && OUT_REG && $stable(MODE))
			|-> DATA_OUT == $past(res);
	endproperty
	a_out_reg: assert property (p_out_reg)
		else $error("output register lag wrong");

	property p_shift_chain;
		(SHIFT_A_EN && !is_36) |=> st.op_a[1] == $past(st.op_a[0]);
	endproperty
	a_shift_chain: assert property (p_shift_chain)
		else $error("operand chain did not shift");

	property p_no_shift_36;
		is_36 |=> st.op_a[0] == $past(DATA_A[0]);
	endproperty
	a_no_shift_36: assert property (p_no_shift_36)
		else $error("wide size used the chain");

	property p_wide;
		(is_36 && MODE == MAS_SIMPLE && !OUT_REG) [*2] ##0 $stable(ctl)
			|-> DATA_OUT[3:0] == $past(wide_ref[MAS_WIDE_W-1:0]);
	endproperty
	a_wide: assert property (p_wide)
		else $error("wide product wrong");

	property p_ctl_twice;
		(CTRL_STAGES == MAS_CTL_TWICE) [*3] |-> ctl == $past(ctl_now, 2);
	endproperty
	a_ctl_twice: assert property (p_ctl_twice)
		else $error("two-stage control latency wrong");

	c_mac_ovf: cover property (is_mac && OVERFLOW != '0);
	c_add4_9: cover property (MODE == MAS_ADD4 && SIZE == MAS_W9);
	c_wide: cover property (is_36 && MODE == MAS_SIMPLE);
	c_fir: cover property (MODE == MAS_ADD4 && SHIFT_A_EN && SHIFT_B_EN);
endmodule
`default_nettype wire

// >>> dv/mas_user_model.sv
// Far-side user logic: held overflow flags and an outside cascade adder.
`timescale 1ns/1ps
`default_nettype none
module mas_user_model (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_b,
	// Slice results
	input  wire mas_pkg::mas_oct_t data_out,
	input  wire logic [1:0]        overflow,
	// Held flags and cascade sum
	output logic [1:0]             ovf_held,
	output logic [71:0]            tap_sum
);
	import mas_pkg::*;
	typedef struct packed {
		logic [1:0]  held;
		logic [71:0] sum;
	} mas_user_s;
	mas_user_s st;
	mas_user_s next_st;
	// The slice flag lasts one cycle, so a lasting flag must live out here.
	always_comb begin
		next_st = st;
		next_st.held = st.held | overflow;
		next_st.sum = data_out[3:0] + data_out[7:4];
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign ovf_held = st.held;
	assign tap_sum = st.sum;
endmodule
`default_nettype wire

// >>> dv/mas_slice_test.sv
// Self-checking bench for the multiply/add slice.
`timescale 1ns/1ps
`default_nettype none
module mas_slice_test;
	import mas_pkg::*;
	// ------------------------------------------------------------
	// Stimulus, observation and tables
	// ------------------------------------------------------------
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	mas_mode_e   mode = MAS_SIMPLE;
	mas_size_e   size = MAS_W18;
	logic        out_reg = 1'b0;
	logic [1:0]  stages = 2'h0;
	logic        a_en = 1'b0;
	logic        b_en = 1'b0;
	logic        sign_a = 1'b0;
	logic        sign_b = 1'b0;
	logic        up = 1'b1;
	logic        lo = 1'b1;
	logic [1:0]  acc_load = 2'h0;
	mas_quad_t   data_a = '0;
	mas_quad_t   data_b = '0;
	mas_lane_t   si_a = 18'h2_AAAA;
	mas_lane_t   si_b = 18'h1_5555;
	mas_oct_t    dout;
	logic [1:0]  ovf;
	mas_lane_t   sh_a;
	mas_lane_t   sh_b;
	logic [1:0]  held;
	logic [71:0] tap;
	logic [143:0] e;
	int          bad_count = 0;
	int          checked = 0;
	// Operands laid out as a complex product: a*c, b*d, a*d, b*c.
	localparam mas_quad_t op_a = {18'h0_1234, 18'h2_0003,
		18'h0_1234, 18'h2_0003};
	localparam mas_quad_t op_b = {18'h3_FF00, 18'h0_0077,
		18'h0_0077, 18'h3_FF00};
	localparam mas_mode_e tm [7] = '{MAS_SIMPLE, MAS_SIMPLE, MAS_SIMPLE,
		MAS_ADD2, MAS_ADD2, MAS_ADD4, MAS_ADD4};
	localparam mas_size_e tz [7] = '{MAS_W9, MAS_W18, MAS_W36,
		MAS_W9, MAS_W18, MAS_W9, MAS_W18};

	always #12.5 mclk = ~mclk;

	mas_slice dut (
		.MCLK(mclk), .RST_B(rst_b), .MODE(mode), .SIZE(size),
		.OUT_REG(out_reg), .CTRL_STAGES(stages),
		.SHIFT_A_EN(a_en), .SHIFT_B_EN(b_en),
		.SIGN_A(sign_a), .SIGN_B(sign_b),
		.ADD_SUBTRACT_SELECT_UPPER(up), .ADD_SUBTRACT_SELECT_LOWER(lo),
		.ACC_LOAD(acc_load), .DATA_A(data_a), .DATA_B(data_b),
		.DATA_OUT(dout), .OVERFLOW(ovf),
		.SHIFT_IN_A(si_a), .SHIFT_IN_B(si_b),
		.SHIFT_OUT_A(sh_a), .SHIFT_OUT_B(sh_b)
	);

	mas_user_model partner (
		.mclk(mclk), .rst_b(rst_b), .data_out(dout), .overflow(ovf),
		.ovf_held(held), .tap_sum(tap)
	);

	// ------------------------------------------------------------
	// Reference arithmetic
	// ------------------------------------------------------------
	// The full 72-bit product of extended operands is already correctly
	// extended, since the result is signed whenever either side is.
	function automatic logic [71:0] mul(logic [35:0] a, logic [35:0] b,
		int w);
		logic [71:0] x;
		logic [71:0] y;
		x = 72'(a);
		y = 72'(b);
		if (sign_a && a[w-1]) x = x | ({72{1'b1}} << w);
		if (sign_b && b[w-1]) y = y | ({72{1'b1}} << w);
		return x * y;
	endfunction

	function automatic logic [71:0] as2(logic [71:0] x, logic [71:0] y,
		logic s);
		return s ? x + y : x - y;
	endfunction

	function automatic logic [143:0] expect_out(mas_quad_t a, mas_quad_t b);
		logic [71:0] p [4];
		logic [71:0] l [4];
		logic [71:0] h [4];
		logic [71:0] s0, s1, s2, s3, t0, t1;
		for (int i = 0; i < 4; i++) begin
			p[i] = mul(36'(a[i]), 36'(b[i]), 18);
			l[i] = mul(36'(a[i][8:0]), 36'(b[i][8:0]), 9);
			h[i] = mul(36'(a[i][17:9]), 36'(b[i][17:9]), 9);
		end
		t0 = as2(p[0], p[1], up);
		t1 = as2(p[2], p[3], lo);
		s0 = as2(l[0], l[1], up);
		s1 = as2(h[0], h[1], up);
		s2 = as2(l[2], l[3], lo);
		s3 = as2(h[2], h[3], lo);
		if (mode == MAS_SIMPLE && size == MAS_W36)
			return {72'h0, mul({a[1], a[0]}, {b[1], b[0]}, 36)};
		if (mode == MAS_SIMPLE && size == MAS_W18)
			return {p[3][35:0], p[2][35:0], p[1][35:0], p[0][35:0]};
		if (mode == MAS_SIMPLE)
			return {h[3][17:0], l[3][17:0], h[2][17:0], l[2][17:0],
				h[1][17:0], l[1][17:0], h[0][17:0], l[0][17:0]};
		if (size == MAS_W18)
			return (mode == MAS_ADD2) ? {t1, t0} : {72'h0, t0 + t1};
		if (mode == MAS_ADD2)
			return {s3[35:0], s2[35:0], s1[35:0], s0[35:0]};
		return {s1 + s3, s0 + s2};
	endfunction

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Inputs move 1 ns after an edge, so every sample sees settled flops.
	task automatic tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(logic [143:0] got, logic [143:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step(logic [1:0] ld, logic u, logic l,
		logic [51:0] e0, logic [51:0] e1, logic [1:0] ov);
		acc_load <= ld;
		up <= u;
		lo <= l;
		tick(1);
		chk(dout, {20'h0, e1, 20'h0, e0});
		chk(144'(ovf), 144'(ov));
	endtask

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		tick(6);
		rst_b <= 1'b1;
		tick(1);
		chk(dout, '0);
		chk(144'({ovf, sh_a, sh_b}), '0);
		data_a <= op_a;
		data_b <= op_b;
		acc_load <= 2'h3;
		tick(1);
		chk(dout, '0);
		tick(1);
		chk(dout, expect_out(op_a, op_b));
		for (int i = 0; i < 7; i++) begin
			for (int s = 0; s < 4; s++) begin
				mode <= tm[i];
				size <= tz[i];
				out_reg <= i[1] ^ s[1];
				up <= i[0];
				lo <= !i[0];
				a_en <= (tz[i] == MAS_W36);
				b_en <= (tz[i] == MAS_W36);
				sign_a <= s[1];
				sign_b <= s[0];
				tick(4);
				e = expect_out(op_a, op_b);
				chk(dout, e);
				chk(144'(ovf), '0);
				if (tm[i] == MAS_ADD4) begin
					tick(1);
					chk(144'(tap), 144'(72'(e[71:0] + e[143:72])));
				end
			end
		end
		// Units one and three carry junk that must not reach the totals.
		mode <= MAS_MAC;
		size <= MAS_W18;
		out_reg <= 1'b0;
		a_en <= 1'b0;
		b_en <= 1'b0;
		sign_a <= 1'b0;
		sign_b <= 1'b0;
		data_a <= {18'h0_0002, 18'h3_FFFF, 18'h0_0003, 18'h3_FFFF};
		data_b <= {18'h0_0007, 18'h3_FFFF, 18'h0_0005, 18'h3_FFFF};
		tick(3);
		step(2'h3, 1'b1, 1'b1, 52'd15, 52'd14, 2'h0);
		step(2'h0, 1'b1, 1'b1, 52'd30, 52'd28, 2'h0);
		step(2'h0, 1'b0, 1'b1, 52'd15, 52'd42, 2'h0);
		step(2'h0, 1'b0, 1'b1, 52'd0, 52'd56, 2'h0);
		step(2'h0, 1'b0, 1'b0, 52'hF_FFFF_FFFF_FFF1, 52'd42, 2'h1);
		step(2'h0, 1'b1, 1'b0, 52'd0, 52'd28, 2'h1);
		step(2'h0, 1'b1, 1'b1, 52'd15, 52'd42, 2'h0);
		chk(144'(held), 144'(2'h1));
		step(2'h1, 1'b1, 1'b1, 52'd15, 52'd56, 2'h0);
		step(2'h0, 1'b1, 1'b1, 52'd30, 52'd70, 2'h0);
		stages <= 2'h1;
		step(2'h0, 1'b1, 1'b1, 52'd45, 52'd84, 2'h0);
		step(2'h1, 1'b1, 1'b1, 52'd60, 52'd98, 2'h0);
		step(2'h0, 1'b1, 1'b1, 52'd15, 52'd112, 2'h0);
		// Two stages: the load driven two steps back, already taken once at one stage, lands again now.
		stages <= 2'h2;
		step(2'h0, 1'b1, 1'b1, 52'd15, 52'd126, 2'h0);
		step(2'h0, 1'b1, 1'b1, 52'd30, 52'd140, 2'h0);
		step(2'h0, 1'b1, 1'b1, 52'd45, 52'd154, 2'h0);
		mode <= MAS_ADD4;
		stages <= 2'h0;
		a_en <= 1'b1;
		b_en <= 1'b1;
		tick(6);
		chk(144'({sh_a, sh_b}), 144'({si_a, si_b}));
		chk(dout, expect_out({4{si_a}}, {4{si_b}}));
		test_done();
	end
endmodule
`default_nettype wire
